// ---- hdl/harmonic_restraint_decision.sv ----
`timescale 1ns/100ps
`include "hrd_cfg.svh"

// Functional notes
// - Harmonic over fundamental above threshold restrains
// - Ratio high 25 ms arms drop-off extension, 20.83 at 60 Hz
// - Extension lasts 15 ms, 12.5 at 60 Hz
// - Inrush restraint needs inrush or external fault
// - Independent second harmonic logic per phase
// - Aggregate inrush is OR of phases
// - Aggregate covers both activation causes
// - Inrush condition while de-energised or recently energised
// - Inrush clears after 5 s current, 4.16667 at 60 Hz, no second harmonic restraint
// - External fault on angle difference of 75 degrees
// - Angle valid only above 10% on both sides
// - Per-phase high second harmonic flag, ungated
// - Per-phase and aggregate fifth harmonic flags
// - Fifth path same timing, minimum current gate
module harmonic_restraint_decision
  import hrd_pkg::*;
#(
  parameter int CNT_W = 8,
  parameter int INR_CNT_W = 13,
  parameter int INR50_TICKS = `HRD_TICKS(`HRD_INR50_US),
  parameter int INR60_TICKS = `HRD_TICKS(`HRD_INR60_US)
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Timing
  input wire logic sampleTick,
  input wire logic freqSel60,
  // Fourier components and side currents, per phase
  input wire hrd_meas_type [2:0] measIn,
  input wire hrd_side_type [2:0] sideIn,
  // Register port
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  // Restraint flags
  output logic [2:0] h2HighPhase,
  output logic [2:0] inrushRestraintPhase,
  output logic inrushRestraintAny,
  output logic [2:0] h5RestraintPhase,
  output logic h5RestraintAny,
  output logic inrushCond,
  output logic extFault,
  // Interrupt
  output logic irq
);

  localparam logic [CNT_W-1:0] PICK50 = CNT_W'(`HRD_TICKS(`HRD_PICK50_US));
  localparam logic [CNT_W-1:0] PICK60 = CNT_W'(`HRD_TICKS(`HRD_PICK60_US));
  localparam logic [CNT_W-1:0] DROP50 = CNT_W'(`HRD_TICKS(`HRD_DROP50_US));
  localparam logic [CNT_W-1:0] DROP60 = CNT_W'(`HRD_TICKS(`HRD_DROP60_US));
  localparam logic [INR_CNT_W-1:0] INR50 = INR_CNT_W'(INR50_TICKS);
  localparam logic [INR_CNT_W-1:0] INR60 = INR_CNT_W'(INR60_TICKS);

  // Harmonic above fund at the threshold percentage, without a divider
  function automatic logic ratioAbove(input logic [`HRD_MAG_W-1:0] harm,
                                      input logic [`HRD_MAG_W-1:0] fund,
                                      input logic [`HRD_THR_W-1:0] pct);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = 32'(harm) * 32'd100;
    rhs = 32'(fund) * 32'(pct);
    return lhs > rhs;
  endfunction

  // Magnitude above a percentage of the reference current
  function automatic logic magAbove(input logic [`HRD_MAG_W-1:0] mag,
                                    input logic [31:0] pct);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = 32'(mag) * 32'd100;
    rhs = pct * 32'(`HRD_REF_ONE);
    return lhs > rhs;
  endfunction

  // Smaller angle between two phasors, degrees in 0..180
  function automatic logic [`HRD_ANG_W-1:0] angleGap(input logic [`HRD_ANG_W-1:0] a,
                                                     input logic [`HRD_ANG_W-1:0] b);
    logic [`HRD_ANG_W-1:0] d;
    d = (a >= b) ? a - b : b - a;
    return (d > `HRD_HALF_TURN_DEG) ? `HRD_FULL_TURN_DEG - d : d;
  endfunction

  // Frequency select pin synchroniser
  logic sel60MetaFf;
  logic sel60Ff;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sel60MetaFf <= 1'b0;
      sel60Ff <= 1'b0;
    end else begin
      sel60MetaFf <= freqSel60;
      sel60Ff <= sel60MetaFf;
    end
  end

  logic [CNT_W-1:0] pickTicks;
  logic [CNT_W-1:0] dropTicks;
  logic [INR_CNT_W-1:0] inrTicks;

  assign pickTicks = sel60Ff ? PICK60 : PICK50;
  assign dropTicks = sel60Ff ? DROP60 : DROP50;
  assign inrTicks = sel60Ff ? INR60 : INR50;

  // Configuration register
  logic [`HRD_THR_W-1:0] h2ThrFf;
  logic [`HRD_THR_W-1:0] h5ThrFf;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      h2ThrFf <= `HRD_H2_THR_RST;
      h5ThrFf <= `HRD_H5_THR_RST;
    end else if (regWr && regAddr == `HRD_CFG_ADDR) begin
      // Range 5..50 is software's duty, stored as written
      h2ThrFf <= regWdata[`HRD_H2_THR_LSB +: `HRD_THR_W];
      h5ThrFf <= regWdata[`HRD_H5_THR_LSB +: `HRD_THR_W];
    end
  end

  // Per-phase decisions
  logic [2:0] h2Ratio;
  logic [2:0] h5Ratio;
  logic [2:0] h2Restr;
  logic [2:0] h5Restr;
  logic [2:0] curOn;
  logic [2:0] angleFault;

  for (genvar p = 0; p < 3; p++) begin : gPhase
    assign h2Ratio[p] = ratioAbove(measIn[p].h2, measIn[p].fund, h2ThrFf);
    assign h5Ratio[p] = ratioAbove(measIn[p].h5, measIn[p].fund, h5ThrFf) &&
                        magAbove(measIn[p].fund, `HRD_MIN_DIFF_PCT);
    assign curOn[p] = magAbove(sideIn[p].magA, `HRD_CUR_ON_PCT);
    assign angleFault[p] = magAbove(sideIn[p].magA, `HRD_EXT_VALID_PCT) &&
                           magAbove(sideIn[p].magB, `HRD_EXT_VALID_PCT) &&
                           angleGap(sideIn[p].angA, sideIn[p].angB) >=
                           `HRD_EXT_ANGLE_DEG;

    // Separate instances keep phases free of shared state
    hrd_restraint_timer #(.CNT_W(CNT_W)) uH2 (
      .mclk(mclk),
      .rstn(rstn),
      .sampleTick(sampleTick),
      .pickTicks(pickTicks),
      .dropTicks(dropTicks),
      .ratioHigh(h2Ratio[p]),
      .restraint(h2Restr[p])
    );

    hrd_restraint_timer #(.CNT_W(CNT_W)) uH5 (
      .mclk(mclk),
      .rstn(rstn),
      .sampleTick(sampleTick),
      .pickTicks(pickTicks),
      .dropTicks(dropTicks),
      .ratioHigh(h5Ratio[p]),
      .restraint(h5Restr[p])
    );
  end

  // External fault condition, refreshed per sample tick
  logic extFaultFf;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      extFaultFf <= 1'b0;
    end else if (sampleTick) begin
      extFaultFf <= |angleFault;
    end
  end

  // Inrush condition: energised with clean current long enough to clear
  logic inrushCondFf;
  logic [INR_CNT_W-1:0] inrCntFf;
  logic energisedClean;
  logic [INR_CNT_W-1:0] inrInc;

  assign energisedClean = (|curOn) && !(|h2Restr);
  assign inrInc = inrCntFf + 1'b1;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      inrushCondFf <= 1'b1;
      inrCntFf <= '0;
    end else if (sampleTick) begin
      if (!(|curOn)) begin
        inrushCondFf <= 1'b1;
        inrCntFf <= '0;
      end else if (!energisedClean) begin
        inrCntFf <= '0;
      end else if (inrushCondFf) begin
        inrCntFf <= inrInc;
        if (inrInc >= inrTicks) begin
          inrushCondFf <= 1'b0;
        end
      end
    end
  end

  // Output flags
  logic [2:0] nxt_inrushPhase;
  logic [2:0] inrushPhaseFf;
  logic [2:0] h2HighFf;
  logic [2:0] h5PhaseFf;
  logic inrushAnyFf;
  logic h5AnyFf;

  assign nxt_inrushPhase = h2Restr & {3{inrushCondFf | extFaultFf}};

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      inrushPhaseFf <= '0;
      h2HighFf <= '0;
      h5PhaseFf <= '0;
      inrushAnyFf <= 1'b0;
      h5AnyFf <= 1'b0;
    end else begin
      inrushPhaseFf <= nxt_inrushPhase;
      h2HighFf <= h2Restr;
      h5PhaseFf <= h5Restr;
      inrushAnyFf <= |nxt_inrushPhase;
      h5AnyFf <= |h5Restr;
    end
  end

  assign h2HighPhase = h2HighFf;
  assign inrushRestraintPhase = inrushPhaseFf;
  assign inrushRestraintAny = inrushAnyFf;
  assign h5RestraintPhase = h5PhaseFf;
  assign h5RestraintAny = h5AnyFf;
  assign inrushCond = inrushCondFf;
  assign extFault = extFaultFf;

  // Interrupt events: restraint onsets and energised transition
  logic inrushAnyDly;
  logic h5AnyDly;
  logic inrushCondDly;
  logic [`HRD_IRQ_W-1:0] irqEvent;
  logic [`HRD_IRQ_W-1:0] irqStatFf;
  logic [`HRD_IRQ_W-1:0] irqMaskFf;
  logic [`HRD_IRQ_W-1:0] irqClear;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      inrushAnyDly <= 1'b0;
      h5AnyDly <= 1'b0;
      inrushCondDly <= 1'b1;
    end else begin
      inrushAnyDly <= inrushAnyFf;
      h5AnyDly <= h5AnyFf;
      inrushCondDly <= inrushCondFf;
    end
  end

  always_comb begin
    irqEvent = '0;
    irqEvent[`HRD_IRQ_INRUSH_BIT] = inrushAnyFf && !inrushAnyDly;
    irqEvent[`HRD_IRQ_H5_BIT] = h5AnyFf && !h5AnyDly;
    irqEvent[`HRD_IRQ_ENERGISED_BIT] = !inrushCondFf && inrushCondDly;
  end

  assign irqClear = (regWr && regAddr == `HRD_IRQ_STAT_ADDR) ?
                    regWdata[`HRD_IRQ_W-1:0] : '0;

  // New events win over a simultaneous write-one-to-clear
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqStatFf <= '0;
    end else begin
      irqStatFf <= (irqStatFf & ~irqClear) | irqEvent;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqMaskFf <= '0;
    end else if (regWr && regAddr == `HRD_IRQ_MASK_ADDR) begin
      irqMaskFf <= regWdata[`HRD_IRQ_W-1:0];
    end
  end

  logic irqFf;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irqFf <= 1'b0;
    end else begin
      irqFf <= |(irqStatFf & irqMaskFf);
    end
  end

  assign irq = irqFf;

  // Read data, valid only the cycle after the strobe
  logic [31:0] nxt_rdata;
  logic [31:0] rdataFf;

  always_comb begin
    nxt_rdata = '0;
    if (!regRd) begin
      nxt_rdata = '0;
    end else if (regAddr == `HRD_CFG_ADDR) begin
      nxt_rdata[`HRD_H2_THR_LSB +: `HRD_THR_W] = h2ThrFf;
      nxt_rdata[`HRD_H5_THR_LSB +: `HRD_THR_W] = h5ThrFf;
    end else if (regAddr == `HRD_FLAGS_ADDR) begin
      nxt_rdata[12:0] = {sel60Ff, extFaultFf, inrushCondFf, h5AnyFf, h5PhaseFf,
                         inrushAnyFf, inrushPhaseFf, h2HighFf[2:1]};
      nxt_rdata[13] = h2HighFf[0];
    end else if (regAddr == `HRD_IRQ_STAT_ADDR) begin
      nxt_rdata[`HRD_IRQ_W-1:0] = irqStatFf;
    end else if (regAddr == `HRD_IRQ_MASK_ADDR) begin
      nxt_rdata[`HRD_IRQ_W-1:0] = irqMaskFf;
    end else begin
      nxt_rdata = '0;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rdataFf <= '0;
    end else begin
      rdataFf <= nxt_rdata;
    end
  end

  assign regRdata = rdataFf;

endmodule

// ---- hdl/hrd_cfg.svh ----
`ifndef HRD_CFG_SVH
`define HRD_CFG_SVH

// Measurement scaling: magnitudes are unsigned, HRD_REF_ONE means 1.0 p.u.
`define HRD_MAG_W 16
`define HRD_ANG_W 9
`define HRD_REF_ONE 16'h1000

// Sample tick period and timer figures, all in microseconds
`define HRD_TICK_US 1000
`define HRD_PICK50_US 25000
`define HRD_PICK60_US 20830
`define HRD_DROP50_US 15000
`define HRD_DROP60_US 12500
`define HRD_INR50_US 5000000
`define HRD_INR60_US 4166670
// Least times round up to whole ticks, never below one
`define HRD_TICKS(t) ((((t) + `HRD_TICK_US - 1) / `HRD_TICK_US) < 1 ? 1 : \
  (((t) + `HRD_TICK_US - 1) / `HRD_TICK_US))

// Level thresholds
`define HRD_CUR_ON_PCT 32'd2
`define HRD_EXT_VALID_PCT 32'd10
`define HRD_MIN_DIFF_PCT 32'd10
`define HRD_EXT_ANGLE_DEG 9'd75
`define HRD_FULL_TURN_DEG 9'd360
`define HRD_HALF_TURN_DEG 9'd180

// Register offsets
`define HRD_CFG_ADDR 4'h0
`define HRD_FLAGS_ADDR 4'h4
`define HRD_IRQ_STAT_ADDR 4'h8
`define HRD_IRQ_MASK_ADDR 4'hC

// Field positions and reset values
`define HRD_H2_THR_LSB 0
`define HRD_H5_THR_LSB 8
`define HRD_THR_W 6
`define HRD_H2_THR_RST 6'h0F
`define HRD_H5_THR_RST 6'h19
`define HRD_IRQ_W 3
`define HRD_IRQ_INRUSH_BIT 0
`define HRD_IRQ_H5_BIT 1
`define HRD_IRQ_ENERGISED_BIT 2

`endif

// ---- hdl/hrd_pkg.sv ----
`include "hrd_cfg.svh"

package hrd_pkg;

  // Gray sequence along idle, pickup, held, drop-off
  typedef enum logic [1:0] {
    HRD_IDLE = 2'b00,
    HRD_PICK = 2'b01,
    HRD_HELD = 2'b11,
    HRD_DROP = 2'b10
  } hrd_tstate_type;

  typedef struct packed {
    logic [`HRD_MAG_W-1:0] fund;
    logic [`HRD_MAG_W-1:0] h2;
    logic [`HRD_MAG_W-1:0] h5;
  } hrd_meas_type;

  typedef struct packed {
    logic [`HRD_MAG_W-1:0] magA;
    logic [`HRD_MAG_W-1:0] magB;
    logic [`HRD_ANG_W-1:0] angA;
    logic [`HRD_ANG_W-1:0] angB;
  } hrd_side_type;

endpackage

// ---- hdl/hrd_restraint_timer.sv ----
`timescale 1ns/100ps
`include "hrd_cfg.svh"

module hrd_restraint_timer
  import hrd_pkg::*;
#(
  parameter int CNT_W = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Timing
  input wire logic sampleTick,
  input wire logic [CNT_W-1:0] pickTicks,
  input wire logic [CNT_W-1:0] dropTicks,
  // Decision
  input wire logic ratioHigh,
  output logic restraint
);

  hrd_tstate_type stateFf;
  hrd_tstate_type nxt_state;
  logic [CNT_W-1:0] cntFf;
  logic [CNT_W-1:0] nxt_cnt;
  logic [CNT_W-1:0] cntInc;

  assign cntInc = cntFf + 1'b1;

  always_comb begin
    nxt_state = stateFf;
    nxt_cnt = cntFf;
    if (sampleTick) begin
      case (stateFf)
        HRD_IDLE: begin
          nxt_cnt = '0;
          if (ratioHigh) begin
            nxt_state = HRD_PICK;
          end
        end
        HRD_PICK: begin
          if (!ratioHigh) begin
            // A run that just reached full length still earns the extension
            nxt_cnt = '0;
            if (cntInc >= pickTicks) begin
              nxt_state = HRD_DROP;
            end else begin
              nxt_state = HRD_IDLE;
            end
          end else begin
            nxt_cnt = cntInc;
            if (cntInc >= pickTicks) begin
              nxt_state = HRD_HELD;
            end
          end
        end
        HRD_HELD: begin
          nxt_cnt = '0;
          if (!ratioHigh) begin
            nxt_state = HRD_DROP;
          end
        end
        default: begin
          // A fresh high ratio must again persist to earn an extension
          if (ratioHigh) begin
            nxt_state = HRD_PICK;
            nxt_cnt = '0;
          end else begin
            nxt_cnt = cntInc;
            if (cntInc >= dropTicks) begin
              nxt_state = HRD_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      stateFf <= HRD_IDLE;
      cntFf <= '0;
    end else begin
      stateFf <= nxt_state;
      cntFf <= nxt_cnt;
    end
  end

  assign restraint = (stateFf != HRD_IDLE);

endmodule

// ---- sim/harmonic_restraint_decision_tb.sv ----
`timescale 1ns/100ps
`include "hrd_cfg.svh"

module harmonic_restraint_decision_tb
  import hrd_pkg::*;
;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic freqSel60 = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [2:0] h2On = 3'h0;
  logic [2:0] h5On = 3'h0;
  logic energ = 1'b0;
  logic magLow = 1'b0;
  logic [8:0] angGap = 9'h000;
  logic sampleTick;
  hrd_meas_type [2:0] measIn;
  hrd_side_type [2:0] sideIn;
  logic [31:0] regRdata;
  logic [2:0] h2HighPhase, inrushRestraintPhase, h5RestraintPhase;
  logic inrushRestraintAny, h5RestraintAny, inrushCond, extFault, irq;
  int n_fail = 0;
  int cmp_count = 0;

  initial begin
    forever #50 mclk = ~mclk;
  end

  // Short inrush counts keep the run brief
  harmonic_restraint_decision #(.INR50_TICKS(8), .INR60_TICKS(6)) u_dut (
    .mclk(mclk), .rstn(rstn), .sampleTick(sampleTick), .freqSel60(freqSel60),
    .measIn(measIn), .sideIn(sideIn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .h2HighPhase(h2HighPhase),
    .inrushRestraintPhase(inrushRestraintPhase), .inrushRestraintAny(inrushRestraintAny),
    .h5RestraintPhase(h5RestraintPhase), .h5RestraintAny(h5RestraintAny),
    .inrushCond(inrushCond), .extFault(extFault), .irq(irq));

  hrd_fourier_model u_far (
    .mclk(mclk), .rstn(rstn), .h2On(h2On), .h5On(h5On), .energ(energ), .magLow(magLow),
    .angGap(angGap), .sampleTick(sampleTick), .measIn(measIn), .sideIn(sideIn));

  task automatic chk_reg(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk_flag(input string nm, input logic [2:0] exp, input logic [2:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %b seen %b", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1;
    chk_reg(nm, exp, regRdata);
  endtask

  // Waits n ticks, then lets the two-edge output lag land
  task automatic wt(input int n);
    repeat (n) @(posedge mclk iff sampleTick);
    repeat (2) @(posedge mclk);
    #1;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #600000;
    n_fail++;
    report_and_stop();
  end

  initial begin
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rd(`HRD_CFG_ADDR, 32'h0000190F, "cfg");
    rd(`HRD_FLAGS_ADDR, 32'h00000400, "flags");
    rd(4'h2, 32'h0, "unmapped");
    wr(`HRD_IRQ_MASK_ADDR, 32'h1);
    rd(`HRD_IRQ_MASK_ADDR, 32'h1, "mask");
    $display("test registers done");
    wr(`HRD_CFG_ADDR, 32'h00001919);
    @(posedge mclk);
    h2On <= 3'h1;
    wt(3);
    chk_flag("h2High", 3'h0, h2HighPhase);
    wr(`HRD_CFG_ADDR, 32'h00001918);
    wt(2);
    chk_flag("h2High", 3'h1, h2HighPhase);
    chk_flag("inrush", 3'h1, inrushRestraintPhase);
    chk_flag("inrushAny", 3'h1, {2'h0, inrushRestraintAny});
    chk_flag("irq", 3'h1, {2'h0, irq});
    rd(`HRD_IRQ_STAT_ADDR, 32'h1, "stat");
    wr(`HRD_IRQ_STAT_ADDR, 32'h1);
    wt(1);
    chk_flag("irq", 3'h0, {2'h0, irq});
    wt(30);
    @(posedge mclk);
    h2On <= 3'h0;
    wt(15);
    chk_flag("h2High", 3'h1, h2HighPhase);
    wt(0);
    chk_flag("h2High", 3'h0, h2HighPhase);
    // One tick short of pickup: no extension
    @(posedge mclk);
    h2On <= 3'h1;
    wt(23);
    @(posedge mclk);
    h2On <= 3'h0;
    wt(2);
    chk_flag("h2High", 3'h0, h2HighPhase);
    // Exactly full pickup length: extended
    @(posedge mclk);
    h2On <= 3'h1;
    wt(24);
    @(posedge mclk);
    h2On <= 3'h0;
    wt(2);
    chk_flag("h2High", 3'h1, h2HighPhase);
    wt(13);
    chk_flag("h2High", 3'h0, h2HighPhase);
    $display("test timing done");
    @(posedge mclk);
    energ <= 1'b1;
    wt(6);
    chk_flag("inrCond", 3'h1, {2'h0, inrushCond});
    wt(0);
    chk_flag("inrCond", 3'h0, {2'h0, inrushCond});
    @(posedge mclk);
    h2On <= 3'h4;
    wt(2);
    chk_flag("h2High", 3'h4, h2HighPhase);
    chk_flag("inrush", 3'h0, inrushRestraintPhase);
    @(posedge mclk);
    angGap <= 9'd75;
    wt(2);
    chk_flag("ext", 3'h1, {2'h0, extFault});
    chk_flag("inrush", 3'h4, inrushRestraintPhase);
    chk_flag("inrushAny", 3'h1, {2'h0, inrushRestraintAny});
    @(posedge mclk);
    magLow <= 1'b1;
    wt(2);
    chk_flag("ext", 3'h0, {2'h0, extFault});
    @(posedge mclk);
    magLow <= 1'b0;
    angGap <= 9'd74;
    wt(2);
    chk_flag("ext", 3'h0, {2'h0, extFault});
    @(posedge mclk);
    h2On <= 3'h0;
    h5On <= 3'h2;
    wt(2);
    chk_flag("h5", 3'h2, h5RestraintPhase);
    chk_flag("h5Any", 3'h1, {2'h0, h5RestraintAny});
    @(posedge mclk);
    h5On <= 3'h0;
    wt(2);
    chk_flag("h5", 3'h0, h5RestraintPhase);
    $display("test gating done");
    @(posedge mclk);
    energ <= 1'b0;
    freqSel60 <= 1'b1;
    wt(2);
    chk_flag("inrCond", 3'h1, {2'h0, inrushCond});
    @(posedge mclk);
    energ <= 1'b1;
    wt(4);
    chk_flag("inrCond", 3'h1, {2'h0, inrushCond});
    wt(0);
    chk_flag("inrCond", 3'h0, {2'h0, inrushCond});
    @(posedge mclk);
    h2On <= 3'h1;
    wt(23);
    @(posedge mclk);
    h2On <= 3'h0;
    wt(13);
    chk_flag("h2High", 3'h1, h2HighPhase);
    wt(0);
    chk_flag("h2High", 3'h0, h2HighPhase);
    $display("test sixty hertz done");
    report_and_stop();
  end
endmodule

// ---- sim/hrd_chk.sv ----
`timescale 1ns/100ps

module hrd_chk (
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Watched ports
  input wire logic sampleTick,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [2:0] h2HighPhase,
  input wire logic [2:0] inrushRestraintPhase,
  input wire logic inrushRestraintAny,
  input wire logic [2:0] h5RestraintPhase,
  input wire logic h5RestraintAny,
  input wire logic inrushCond,
  input wire logic extFault
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  // Flag edges lag the deciding tick by exactly two edges
  sequence s_tickTwoBack;
    $past(sampleTick, 2);
  endsequence
  sequence s_gateOpen;
    inrushCond || extFault || $past(inrushCond) || $past(extFault);
  endsequence

  property p_inrAny;
    inrushRestraintAny == (|inrushRestraintPhase);
  endproperty
  a_inrAny: assert property (p_inrAny) else $error("inrush aggregate mismatch");
  property p_h5Any;
    h5RestraintAny == (|h5RestraintPhase);
  endproperty
  a_h5Any: assert property (p_h5Any) else $error("fifth aggregate mismatch");
  property p_gate;
    (inrushRestraintPhase != 3'h0) |-> s_gateOpen;
  endproperty
  a_gate: assert property (p_gate) else $error("inrush flag without cause");
  property p_subset;
    (inrushRestraintPhase & ~h2HighPhase) == 3'h0;
  endproperty
  a_subset: assert property (p_subset) else $error("inrush flag without h2 flag");
  property p_rst;
    disable iff (1'b0) !rstn |=> h2HighPhase == 3'h0 && h5RestraintPhase == 3'h0
      && !inrushRestraintAny && inrushCond;
  endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_rise;
    $rose(h2HighPhase[0]) |-> s_tickTwoBack;
  endproperty
  a_rise: assert property (p_rise) else $error("h2 rise off tick");
  property p_fall;
    $fell(h2HighPhase[0]) |-> s_tickTwoBack;
  endproperty
  a_fall: assert property (p_fall) else $error("h2 fall off tick");
  property p_h5Edge;
    $changed(h5RestraintPhase) |-> s_tickTwoBack;
  endproperty
  a_h5Edge: assert property (p_h5Edge) else $error("h5 change off tick");
  property p_inrTick;
    $changed(inrushCond) |-> $past(sampleTick);
  endproperty
  a_inrTick: assert property (p_inrTick) else $error("inrush cond off tick");
  property p_extTick;
    $changed(extFault) |-> $past(sampleTick);
  endproperty
  a_extTick: assert property (p_extTick) else $error("ext fault off tick");
  property p_rdIdle;
    !regRd |=> regRdata == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data outside slot");
endmodule

bind harmonic_restraint_decision hrd_chk u_chk (
  .mclk(mclk), .rstn(rstn), .sampleTick(sampleTick), .regRd(regRd),
  .regRdata(regRdata), .h2HighPhase(h2HighPhase),
  .inrushRestraintPhase(inrushRestraintPhase), .inrushRestraintAny(inrushRestraintAny),
  .h5RestraintPhase(h5RestraintPhase), .h5RestraintAny(h5RestraintAny),
  .inrushCond(inrushCond), .extFault(extFault)
);

// ---- sim/hrd_fourier_model.sv ----
`timescale 1ns/100ps
`include "hrd_cfg.svh"

module hrd_fourier_model
  import hrd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // Scenario knobs
  input wire logic [2:0] h2On,
  input wire logic [2:0] h5On,
  input wire logic energ,
  input wire logic magLow,
  input wire logic [8:0] angGap,
  // Toward the block
  output logic sampleTick,
  output hrd_meas_type [2:0] measIn,
  output hrd_side_type [2:0] sideIn
);
  // Tick every second cycle keeps timer spans short
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      sampleTick <= 1'b0;
    end else begin
      sampleTick <= !sampleTick;
    end
  end

  always_comb begin
    for (int i = 0; i < 3; i++) begin
      measIn[i].fund = `HRD_REF_ONE;
      // Exactly 25 percent, a boundary for a threshold of 25
      measIn[i].h2 = h2On[i] ? 16'h0400 : 16'h0000;
      measIn[i].h5 = h5On[i] ? 16'h0800 : 16'h0000;
      sideIn[i].magA = energ ? `HRD_REF_ONE : 16'h0000;
      // About 5 percent, too small for a valid angle
      sideIn[i].magB = magLow ? 16'h00CC : `HRD_REF_ONE;
      sideIn[i].angA = 9'h000;
      sideIn[i].angB = angGap;
    end
  end
endmodule
